/* File: rtl/scd_ctrl.sv */
// sleep mode, wake-up sequencing and clock divide control with apb registers
// Operation
// [R1] divider code 0..8 divides source by two to the code; 9..15 reserved
// [R2] divide-by-eight option ships programmed, so start-up clock is reduced
// [R3] reset loads divider code 0011 with option programmed, else 0000; code resets to 0000 and loads 0011 on the third edge after release
// [R4] each sleep mode gates its own set of clock domains and oscillators
// [R5] each sleep mode accepts only its listed wake sources
// [R6] timer oscillator and timer 2 wake need timer 2 in asynchronous mode; idle accepts timer 2 wake without it
// [R7] outside idle, external irq zero wakes only in level configuration
// [R8] software picks lowest standby only with external crystal clock
// [R9] sleep needs allow bit set then sleep instruction; mode from select bits
// [R10] select encodings 000,001,010,011,110,111; standby modes need crystal
// [R11] on wake, core halts four cycles plus start-up, then resumes
// [R12] register file and static memory keep contents through sleep
// [R13] reset during sleep wakes device and restarts at reset vector
// [R14] brownout off only in deep modes, off at entry, on at wake
// [R15] wake after brownout off is stretched to about 60 us
// [R16] brownout sleep off is bit 6 of core control, resets to zero
// [R17] brownout sleep off written only through timed enable sequence
// [R18] standby and extended standby resume six cycles after wake
// [R19] software clears allow bit after wake-up
`timescale 1ns/10ps
module scd_ctrl #(
   parameter int STARTUP_CYC = 16
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        sleep_instr,
   input  wire logic        start_div_eight_option,
   input  wire logic        crystal_selected,
   input  wire logic        timer2_async,
   input  wire logic        ext_irq_zero_level,
   input  wire logic [7:0]  wake_req,
   output logic             clk_cpu_en,
   output logic             clk_flash_en,
   output logic             clk_io_en,
   output logic             clk_conv_en,
   output logic             clk_async_en,
   output logic             main_osc_en,
   output logic             timer_osc_en,
   output logic             brownout_detector_on,
   output logic             core_halt,
   output logic             core_resume,
   output logic             sys_clk_tick,
   output logic [3:0]       clk_div_select,
   output logic             irq
);
   localparam logic [10:0] WAKE_BROWN = 11'(scd_pkg::BROWN_WAKE_CYC);
   localparam logic [10:0] WAKE_STBY  = 11'(scd_pkg::STANDBY_WAKE_CYC);
   localparam logic [10:0] WAKE_HALT  = 11'(scd_pkg::HALT_CYC);
   localparam logic [10:0] WAKE_DEEP  = 11'(STARTUP_CYC + scd_pkg::HALT_CYC);
   localparam logic [2:0]  WIN_LEN    = 3'(scd_pkg::TIMED_WIN_CYC);

   // returns {cpu, flash, io, conv, async, main osc, timer osc}
   function automatic logic [6:0] dom_en(input logic [2:0] m, input logic t2a);
      logic [6:0] r;
      r = 7'h00;
      unique case (m)
         scd_pkg::MODE_IDLE:  r = {4'b0011, 1'b1, 1'b1, t2a};
         scd_pkg::MODE_QUIET: r = {4'b0001, 1'b1, 1'b1, t2a};
         scd_pkg::MODE_PDOWN: r = 7'h00;
         scd_pkg::MODE_PSAVE: r = {4'b0000, 1'b1, 1'b0, t2a};
         scd_pkg::MODE_STBY:  r = {4'b0000, 1'b0, 1'b1, 1'b0};
         scd_pkg::MODE_XSTBY: r = {4'b0000, t2a, 1'b1, t2a};
         default:             r = {4'b1111, 1'b1, 1'b1, t2a};
      endcase
      return r;
   endfunction

   // allowed wake sources per mode, ordered as the wake_req bits
   function automatic logic [7:0] wake_ok(input logic [2:0] m, input logic t2a,
                                          input logic lvl0);
      logic [7:0] r;
      logic       z;
      r = 8'h00;
      // [R7] level config only
      z = lvl0;
      unique case (m)
         scd_pkg::MODE_IDLE:  r = 8'hFF;
         scd_pkg::MODE_QUIET: r = {1'b0, 1'b1, 1'b1, 1'b1, t2a, 1'b1, z, 1'b1};
         scd_pkg::MODE_PDOWN,
         scd_pkg::MODE_STBY:  r = {1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, z, 1'b1};
         scd_pkg::MODE_PSAVE,
         scd_pkg::MODE_XSTBY: r = {1'b0, 1'b1, 1'b0, 1'b0, t2a, 1'b1, z, 1'b1};
         default:             r = 8'h00;
      endcase
      return r;
   endfunction

   // registers
   logic        sleep_allow;
   logic [2:0]  sleep_mode_select;
   logic        brownout_sleep_off;
   logic        bso_armed;
   logic [2:0]  bso_win;
   localparam int IRQ_W = scd_pkg::IRQ_NUM;
   logic [IRQ_W-1:0] irq_stat;
   logic [IRQ_W-1:0] irq_mask;

   // control state
   scd_pkg::scd_state_t state;
   scd_pkg::scd_state_t next_state;
   logic [2:0]  act_mode;
   logic        brown_cut;
   logic [10:0] wake_cnt;
   logic [1:0]  strap_cnt;
   logic        strap_meta;
   logic        strap_sync;
   logic [7:0]  wk_meta;
   logic [7:0]  wk_sync;

   // bus decode
   wire         acc       = psel & penable & pready;
   wire         wr        = acc & pwrite;
   wire         hit_sleep = (paddr == scd_pkg::ADDR_SLEEP);
   wire         hit_core  = (paddr == scd_pkg::ADDR_CORE);
   wire         hit_div   = (paddr == scd_pkg::ADDR_DIV);
   wire         hit_stat  = (paddr == scd_pkg::ADDR_STAT);
   wire         hit_irq   = (paddr == scd_pkg::ADDR_IRQ);
   wire         hit_mask  = (paddr == scd_pkg::ADDR_MASK);
   wire         mapped    = hit_sleep | hit_core | hit_div | hit_stat | hit_irq | hit_mask;
   wire         wr_sleep  = wr & hit_sleep;
   wire         wr_core   = wr & hit_core;
   wire         wr_div    = wr & hit_div;

   // sleep entry checks
   wire         is_stby   = (sleep_mode_select == scd_pkg::MODE_STBY) |
                            (sleep_mode_select == scd_pkg::MODE_XSTBY);
   // [R10] legal encodings only
   wire         mode_legal = (sleep_mode_select[2:1] != 2'b10) & (!is_stby | crystal_selected);
   // [R9] allow bit gates entry
   wire         go_sleep  = (state == scd_pkg::ST_RUN) & sleep_instr & sleep_allow & mode_legal;
   wire         refused   = (state == scd_pkg::ST_RUN) & sleep_instr & !go_sleep;

   // [R5] wake qualified by mode
   wire [7:0]   wk_allowed = wake_ok(act_mode, timer2_async, ext_irq_zero_level);
   wire         wake_hit  = (state == scd_pkg::ST_SLEEP) & |(wk_sync & wk_allowed);

   // [R14] deep modes only
   wire         deep_mode = (sleep_mode_select == scd_pkg::MODE_PDOWN) |
                            (sleep_mode_select == scd_pkg::MODE_PSAVE) | is_stby;
   wire         act_stby  = (act_mode == scd_pkg::MODE_STBY) |
                            (act_mode == scd_pkg::MODE_XSTBY);
   wire         act_light = (act_mode == scd_pkg::MODE_IDLE) |
                            (act_mode == scd_pkg::MODE_QUIET);
   // [R15] [R18] [R11] wake length by cause
   wire [10:0]  wake_len  = brown_cut ? WAKE_BROWN :
                            act_stby  ? WAKE_STBY  :
                            act_light ? WAKE_HALT  : WAKE_DEEP;

   // [R17] timed write of the brownout control
   wire         bso_open  = wr_core & pwdata[scd_pkg::BSO_EN_BIT] & pwdata[scd_pkg::BSO_BIT];
   wire         bso_take  = wr_core & !pwdata[scd_pkg::BSO_EN_BIT] & bso_armed;
   // [R1] reserved codes are refused
   wire         div_bad   = wr_div & (pwdata[3:0] > scd_pkg::DIV_MAX_CODE);
   wire         div_load  = wr_div & !div_bad;

   wire [IRQ_W-1:0] irq_set = {div_bad, refused, wake_hit};
   wire [IRQ_W-1:0] irq_clr = (wr & hit_irq) ? pwdata[IRQ_W-1:0] : {IRQ_W{1'b0}};

   wire [6:0]   doms_sleep = dom_en(act_mode, timer2_async);
   wire [6:0]   doms_run   = {5'b11111, 1'b1, timer2_async};
   // [R4] [R6] gate domains while asleep
   wire [6:0]   next_doms  = (state == scd_pkg::ST_SLEEP) ? doms_sleep : doms_run;

   wire [31:0]  rd_stat = {16'h0000, 4'h0, clk_div_select, 1'b0, act_mode,
                           1'b0, brownout_detector_on, state};
   wire [31:0]  next_rdata =
      hit_sleep ? {28'h0000000, sleep_mode_select, sleep_allow} :
      hit_core  ? {25'h0000000, brownout_sleep_off, 6'h00} :
      hit_div   ? {28'h0000000, clk_div_select} :
      hit_stat  ? rd_stat :
      hit_irq   ? {29'h00000000, irq_stat} :
      hit_mask  ? {29'h00000000, irq_mask} : 32'h00000000;

   always_comb begin
      next_state = state;
      unique case (state)
         scd_pkg::ST_RUN:   if (go_sleep) next_state = scd_pkg::ST_SLEEP;
         scd_pkg::ST_SLEEP: if (wake_hit) next_state = scd_pkg::ST_WAKE;
         scd_pkg::ST_WAKE:  if (wake_cnt == 11'h001) next_state = scd_pkg::ST_RUN;
         default:           next_state = scd_pkg::ST_RUN;
      endcase
   end

   // apb slave, one wait state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
      end else begin
         pready  <= psel & penable & !pready;
         pslverr <= psel & penable & !pready & !mapped;
         prdata  <= next_rdata;
      end
   end

   // [R13] async reset returns everything to run state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state     <= scd_pkg::ST_RUN;
         act_mode  <= 3'h0;
         brown_cut <= 1'b0;
         wake_cnt  <= 11'h000;
      end else begin
         state <= next_state;
         if (go_sleep) begin
            act_mode  <= sleep_mode_select;
            // [R14] off at entry when permitted
            brown_cut <= brownout_sleep_off & deep_mode;
         end
         if (wake_hit) begin
            wake_cnt  <= wake_len;
         end else if (wake_cnt != 11'h000) begin
            wake_cnt  <= 11'(wake_cnt - 11'h001);
         end
         // [R14] back on as soon as wake starts
         if (wake_hit) begin
            brown_cut <= 1'b0;
         end
      end
   end

   // software control bits
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sleep_allow       <= 1'b0;
         sleep_mode_select <= 3'h0;
      end else if (wr_sleep) begin
         // [R19] software clears the allow bit here after wake
         sleep_allow       <= pwdata[scd_pkg::SLEEP_ALLOW_BIT];
         sleep_mode_select <= pwdata[scd_pkg::MODE_LSB +: 3];
      end
   end

   // [R16] resets to zero, brownout stays active
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         brownout_sleep_off <= 1'b0;
         bso_armed          <= 1'b0;
         bso_win            <= 3'h0;
      end else begin
         // [R17] arm window, a rewrite inside it does not extend it
         if (bso_open & !bso_armed) begin
            bso_armed <= 1'b1;
            bso_win   <= WIN_LEN;
         end else if (bso_take | (bso_win == 3'h1)) begin
            bso_armed <= 1'b0;
            bso_win   <= 3'h0;
         end else if (bso_win != 3'h0) begin
            bso_win   <= 3'(bso_win - 3'h1);
         end
         if (bso_take) begin
            brownout_sleep_off <= pwdata[scd_pkg::BSO_BIT];
         end
      end
   end

   // strap is caught after release, never by the reset itself
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         strap_meta <= 1'b0;
         strap_sync <= 1'b0;
         strap_cnt  <= 2'h0;
      end else begin
         strap_meta <= start_div_eight_option;
         strap_sync <= strap_meta;
         if (strap_cnt != 2'(scd_pkg::STRAP_SYNC_CYC + 1)) begin
            strap_cnt <= 2'(strap_cnt + 2'h1);
         end
      end
   end

   wire strap_load = (strap_cnt == 2'(scd_pkg::STRAP_SYNC_CYC));

   // [R2] [R3] divider code follows the option once the strap is synchronised after reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clk_div_select <= scd_pkg::DIV_RST_ONE;
      end else if (strap_load) begin
         clk_div_select <= strap_sync ? scd_pkg::DIV_RST_EIGHT : scd_pkg::DIV_RST_ONE;
      end else if (div_load) begin
         clk_div_select <= pwdata[3:0];
      end
   end

   // wake pins cross in through two flops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wk_meta <= 8'h00;
         wk_sync <= 8'h00;
      end else begin
         wk_meta <= wake_req;
         wk_sync <= wk_meta;
      end
   end

   // interrupt status: set beats clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_stat <= {IRQ_W{1'b0}};
         irq_mask <= {IRQ_W{1'b0}};
         irq      <= 1'b0;
      end else begin
         irq_stat <= (irq_stat & ~irq_clr) | irq_set;
         if (wr & hit_mask) begin
            irq_mask <= pwdata[IRQ_W-1:0];
         end
         irq <= |(((irq_stat & ~irq_clr) | irq_set) & irq_mask);
      end
   end

   // clock gating and core handshake outputs
   // [R12] memories are only clock gated, never reset, so contents stay
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {clk_cpu_en, clk_flash_en, clk_io_en, clk_conv_en} <= 4'hF;
         clk_async_en         <= 1'b1;
         main_osc_en          <= 1'b1;
         timer_osc_en         <= 1'b0;
         brownout_detector_on <= 1'b1;
         core_halt            <= 1'b0;
         core_resume          <= 1'b0;
      end else begin
         {clk_cpu_en, clk_flash_en, clk_io_en, clk_conv_en,
          clk_async_en, main_osc_en, timer_osc_en} <= next_doms;
         brownout_detector_on <= !(brown_cut & (next_state == scd_pkg::ST_SLEEP));
         // [R11] core held through the wake count
         core_halt            <= (next_state != scd_pkg::ST_RUN);
         core_resume          <= (state == scd_pkg::ST_WAKE) & (next_state == scd_pkg::ST_RUN);
      end
   end

   // [R1] power-of-two divider
   scd_div #(
      .CODE_W (4)
   ) u_div (
      .pclk    (pclk),
      .presetn (presetn),
      .code    (clk_div_select),
      .tick    (sys_clk_tick)
   );
endmodule // scd_ctrl

/* File: pkg/scd_pkg.sv */
// constants and types for the sleep and clock divide controller
package scd_pkg;
   // register byte offsets
   localparam logic [7:0] ADDR_SLEEP = 8'h00;
   localparam logic [7:0] ADDR_CORE  = 8'h04;
   localparam logic [7:0] ADDR_DIV   = 8'h08;
   localparam logic [7:0] ADDR_STAT  = 8'h0C;
   localparam logic [7:0] ADDR_IRQ   = 8'h10;
   localparam logic [7:0] ADDR_MASK  = 8'h14;
   // field positions
   localparam int SLEEP_ALLOW_BIT = 0;
   localparam int MODE_LSB        = 1;
   localparam int BSO_EN_BIT      = 5;
   localparam int BSO_BIT         = 6;
   localparam int STAT_STATE_LSB  = 0;
   localparam int STAT_BROWN_BIT  = 2;
   localparam int STAT_MODE_LSB   = 4;
   localparam int STAT_DIV_LSB    = 8;
   // divider codes
   localparam logic [3:0] DIV_RST_EIGHT = 4'h3;
   localparam logic [3:0] DIV_RST_ONE   = 4'h0;
   localparam logic [3:0] DIV_MAX_CODE  = 4'h8;
   // wake source indices
   localparam int WK_LINES = 0;
   localparam int WK_IRQ0  = 1;
   localparam int WK_TWI   = 2;
   localparam int WK_TMR2  = 3;
   localparam int WK_MEMRD = 4;
   localparam int WK_CONV  = 5;
   localparam int WK_WDT   = 6;
   localparam int WK_OTHER = 7;
   localparam int WK_NUM   = 8;
   // interrupt status bits
   localparam int IRQ_WAKE     = 0;
   localparam int IRQ_REFUSED  = 1;
   localparam int IRQ_RESERVED = 2;
   localparam int IRQ_NUM      = 3;
   // timing
   localparam int CLK_MHZ          = 20;
   localparam int BROWN_WAKE_US    = 60;
   localparam int BROWN_WAKE_CYC   = BROWN_WAKE_US * CLK_MHZ;
   localparam int HALT_CYC         = 4;
   localparam int STANDBY_WAKE_CYC = 6;
   localparam int TIMED_WIN_CYC    = 4;
   localparam int STRAP_SYNC_CYC   = 2;

   typedef enum logic [2:0] {
      MODE_IDLE   = 3'b000,
      MODE_QUIET  = 3'b001,
      MODE_PDOWN  = 3'b010,
      MODE_PSAVE  = 3'b011,
      MODE_RSV4   = 3'b100,
      MODE_RSV5   = 3'b101,
      MODE_STBY   = 3'b110,
      MODE_XSTBY  = 3'b111
   } scd_mode_t;

   typedef enum logic [1:0] {
      ST_RUN   = 2'b00,
      ST_SLEEP = 2'b01,
      ST_WAKE  = 2'b11
   } scd_state_t;
endpackage

/* File: rtl/scd_div.sv */
// power-of-two clock divider producing a one-cycle tick
`timescale 1ns/10ps
module scd_div #(
   parameter int CODE_W = 4
) (
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic [CODE_W-1:0] code,
   output logic                   tick
);
   logic [7:0] cnt;
   logic [7:0] limit;
   logic       wrap;

   // divide by two to the code, 1 up to 256
   assign limit = 8'((9'h001 << code) - 9'h001);
   // a code lowered to a limit at or below the count wraps at once, so no period is longer than the old one
   assign wrap  = (cnt >= limit);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt  <= 8'h00;
         tick <= 1'b0;
      end else begin
         cnt  <= wrap ? 8'h00 : 8'(cnt + 8'h01);
         tick <= wrap;
      end
   end
endmodule // scd_div

/* File: tb/scd_ctrl_properties.sv */
// concurrent checks on the sleep and clock divide controller ports
`timescale 1ns/10ps
module scd_ctrl_properties (
   input wire logic       pclk,
   input wire logic       presetn,
   input wire logic       sleep_instr,
   input wire logic       timer2_async,
   input wire logic       clk_cpu_en,
   input wire logic       clk_flash_en,
   input wire logic       clk_io_en,
   input wire logic       clk_conv_en,
   input wire logic       timer_osc_en,
   input wire logic       brownout_detector_on,
   input wire logic       core_halt,
   input wire logic       core_resume,
   input wire logic       sys_clk_tick,
   input wire logic [3:0] clk_div_select
);
   // wake length tolerance, count includes wake state cycles
   localparam int BW_LO = 1190;
   localparam int BW_HI = 1210;
   logic        bo_armed;
   logic [11:0] bo_cnt;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bo_armed <= 1'b0;
         bo_cnt   <= 12'h000;
      end else if (!brownout_detector_on) begin
         bo_armed <= 1'b1;
         bo_cnt   <= 12'h000;
      end else if (core_halt) begin
         bo_cnt <= bo_cnt + 12'h001;
      end else begin
         bo_armed <= 1'b0;
      end
   end
   // settled code, so the divider has had time to follow
   sequence tick_busy_s;
      ($stable(clk_div_select) [*3]) ##0 sys_clk_tick && clk_div_select != 4'h0
         ##1 $stable(clk_div_select);
   endsequence
   sequence bo_back_s;
      $fell(core_halt) && bo_armed;
   endsequence
   AST_DIV_RANGE: assert property (clk_div_select <= 4'h8)
      else $error("divider code above eight");
   AST_TICK_GAP: assert property (tick_busy_s |-> !sys_clk_tick)
      else $error("tick too close for divider code");
   AST_HALT_CAUSE: assert property ($rose(core_halt) |-> $past(sleep_instr))
      else $error("halt without sleep instruction");
   // cpu clock gating, enables trail halt by a cycle
   AST_CPU_GATE: assert property (!clk_cpu_en |->
                                  (core_halt || $past(core_halt)) && !clk_flash_en)
      else $error("cpu clock stopped outside sleep");
   AST_DOMAIN_ORDER: assert property (!clk_conv_en |-> !clk_io_en && !clk_cpu_en)
      else $error("io clock runs with converter clock stopped");
   AST_TIMER_OSC: assert property (timer_osc_en |-> timer2_async || $past(timer2_async))
      else $error("timer oscillator on without async timer");
   AST_BROWN_DEEP: assert property (!brownout_detector_on |-> core_halt && !clk_conv_en)
      else $error("detector off outside a deep sleep");
   AST_RESUME_EDGE: assert property (core_resume |-> $fell(core_halt) ##1 !core_resume)
      else $error("resume pulse not tied to halt release");
   AST_BROWN_WAKE: assert property (bo_back_s |-> bo_cnt >= BW_LO && bo_cnt <= BW_HI)
      else $error("wake after detector cut not stretched");
endmodule // scd_ctrl_properties

/* File: tb/scd_ctrl_tb_top.sv */
// self-checking bench for the sleep and clock divide controller
`timescale 1ns/10ps
module scd_ctrl_tb_top;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
   logic [7:0]  paddr, wake_req;
   logic [31:0] pwdata, prdata, rdat;
   logic        sleep_instr, start_div_eight_option, crystal_selected;
   logic        timer2_async, ext_irq_zero_level, rerr, core_halt, core_resume;
   logic        clk_cpu_en, clk_flash_en, clk_io_en, clk_conv_en, clk_async_en;
   logic        main_osc_en, timer_osc_en, brownout_detector_on, sys_clk_tick;
   logic [3:0]  clk_div_select;
   int          num_errors, check_count;
   // short start-up count keeps deep wakes quick
   localparam int STARTUP = 2;
   scd_ctrl #(.STARTUP_CYC(STARTUP)) dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .sleep_instr, .start_div_eight_option,
      .crystal_selected, .timer2_async, .ext_irq_zero_level, .wake_req, .clk_cpu_en,
      .clk_flash_en, .clk_io_en, .clk_conv_en, .clk_async_en, .main_osc_en, .timer_osc_en,
      .brownout_detector_on, .core_halt, .core_resume, .sys_clk_tick, .clk_div_select, .irq);
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic give_verdict;
      $display("errors %0d checks %0d", num_errors, check_count);
      if (num_errors == 0 && check_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // keep holds psel so a following setup runs back to back
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic keep);
      int n;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         num_errors++;
         $display("CHECK FAILED at %0t: no bus answer", $time);
      end
      rdat = prdata;
      rerr = pslverr;
      penable <= 1'b0;
      // idle edge keeps the next setup out of this time step
      if (!keep) begin
         psel <= 1'b0;
         @(posedge pclk);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic keep = 1'b0);
      apb(1'b1, a, d, keep);
   endtask
   task automatic rd(input logic [7:0] a);
      apb(1'b0, a, 32'h0, 1'b0);
   endtask
   task automatic do_reset(input logic opt);
      presetn <= 1'b0;
      start_div_eight_option <= opt;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      repeat (4) @(posedge pclk);
   endtask
   task automatic gap(output int n);
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (sys_clk_tick !== 1'b1 && n < 600);
   endtask
   task automatic go_sleep(input logic [2:0] m, input logic allow);
      wr(scd_pkg::ADDR_SLEEP, 32'({m, allow}));
      sleep_instr <= 1'b1;
      @(posedge pclk);
      sleep_instr <= 1'b0;
      repeat (2) @(posedge pclk);
   endtask
   // watchdog wake, edges counted until the resume pulse
   task automatic wake_up(output int n);
      wake_req <= 8'h40;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (core_resume !== 1'b1 && n < 2000);
      wake_req <= 8'h00;
      @(posedge pclk);
   endtask
   task automatic t_div;
      int n;
      for (int c = 0; c <= 8; c++) begin
         wr(scd_pkg::ADDR_DIV, 32'(c));
         @(posedge pclk);
         chk(32'(clk_div_select), 32'(c));
         gap(n);
         gap(n);
         chk(32'(n), 32'(1 << c));
      end
      wr(scd_pkg::ADDR_DIV, 32'h9);
      @(posedge pclk);
      chk(32'(clk_div_select), 32'h8);
      rd(scd_pkg::ADDR_IRQ);
      chk(32'({rdat[2], irq}), 32'h2);
      wr(scd_pkg::ADDR_MASK, 32'h4);
      repeat (2) @(posedge pclk);
      chk(32'(irq), 32'h1);
      wr(scd_pkg::ADDR_IRQ, 32'h4);
      repeat (2) @(posedge pclk);
      chk(32'(irq), 32'h0);
      rd(8'h18);
      chk({rdat[30:0], rerr}, 32'h1);
      wr(scd_pkg::ADDR_DIV, 32'h0);
   endtask
   task automatic t_sleep;
      logic [2:0] md [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7};
      logic [5:0] dom [6] = '{6'h0F, 6'h07, 6'h00, 6'h02, 6'h01, 6'h03};
      int n;
      int e;
      crystal_selected <= 1'b1;
      timer2_async <= 1'b1;
      ext_irq_zero_level <= 1'b0;
      for (int i = 0; i < 6; i++) begin
         go_sleep(md[i], 1'b1);
         chk(32'({clk_cpu_en, clk_flash_en, clk_io_en, clk_conv_en, clk_async_en,
                  main_osc_en}), 32'(dom[i]));
         if (i > 0) begin
            wake_req <= 8'h82;
            repeat (12) @(posedge pclk);
            chk(32'(core_halt), 32'h1);
         end
         wake_up(n);
         // sync flops, detect edge and resume flop add four
         e = 4 + ((i < 2) ? scd_pkg::HALT_CYC :
                  (i < 4) ? STARTUP + scd_pkg::HALT_CYC : scd_pkg::STANDBY_WAKE_CYC);
         chk(32'(n), 32'(e));
         rd(scd_pkg::ADDR_SLEEP);
         chk(rdat, 32'({md[i], 1'b1}));
      end
      go_sleep(3'h0, 1'b0);
      chk(32'(core_halt), 32'h0);
      go_sleep(3'h4, 1'b1);
      chk(32'(core_halt), 32'h0);
      crystal_selected <= 1'b0;
      go_sleep(3'h6, 1'b1);
      chk(32'(core_halt), 32'h0);
      rd(scd_pkg::ADDR_IRQ);
      chk(32'(rdat[1]), 32'h1);
   endtask
   task automatic t_brown;
      int n;
      rd(scd_pkg::ADDR_CORE);
      chk(32'(rdat[6]), 32'h0);
      wr(scd_pkg::ADDR_CORE, 32'h40);
      rd(scd_pkg::ADDR_CORE);
      chk(32'(rdat[6]), 32'h0);
      wr(scd_pkg::ADDR_CORE, 32'h60, 1'b1);
      wr(scd_pkg::ADDR_CORE, 32'h40);
      rd(scd_pkg::ADDR_CORE);
      chk(32'(rdat[6]), 32'h1);
      go_sleep(3'h0, 1'b1);
      chk(32'(brownout_detector_on), 32'h1);
      wake_up(n);
      go_sleep(3'h2, 1'b1);
      chk(32'(brownout_detector_on), 32'h0);
      wake_up(n);
      chk(32'(n), 32'(scd_pkg::BROWN_WAKE_CYC + 4));
      chk(32'(brownout_detector_on), 32'h1);
      go_sleep(3'h2, 1'b1);
      do_reset(1'b1);
      chk(32'({core_halt, brownout_detector_on, clk_cpu_en}), 32'h3);
      rd(scd_pkg::ADDR_CORE);
      chk(32'(rdat[6]), 32'h0);
      wr(scd_pkg::ADDR_SLEEP, 32'h0);
   endtask
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   initial begin
      repeat (20000) @(posedge pclk);
      num_errors++;
      give_verdict();
   end
   initial begin
      {presetn, psel, penable, pwrite, sleep_instr, crystal_selected} = 6'h00;
      {timer2_async, ext_irq_zero_level, start_div_eight_option} = 3'h1;
      {paddr, wake_req, pwdata} = 48'h0;
      num_errors = 0;
      check_count = 0;
      @(posedge pclk);
      do_reset(1'b1);
      chk(32'(clk_div_select), 32'h3);
      do_reset(1'b0);
      chk(32'(clk_div_select), 32'h0);
      t_div();
      t_sleep();
      t_brown();
      give_verdict();
   end
endmodule // scd_ctrl_tb_top
bind scd_ctrl scd_ctrl_properties scd_chk_u (.pclk, .presetn, .sleep_instr, .timer2_async,
   .clk_cpu_en, .clk_flash_en, .clk_io_en, .clk_conv_en, .timer_osc_en, .brownout_detector_on,
   .core_halt, .core_resume, .sys_clk_tick, .clk_div_select);
